// >>> verilog/icsr_pkg.sv
/*
 * icsr_pkg: constants and carrier types of the interrupt control and
 * status block (offsets, field positions, masks, reset values).
 * Assumes a single 25 MHz clock domain and a 16-bit register port.
 */
package icsr_pkg;
    // register port geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned EXT_N = 3;
    localparam int unsigned PRIO_W = 3;
    localparam int unsigned LEVEL_W = 4;
    // register addresses on the plain port
    localparam logic [3:0] OFS_CONTROL_ONE = 4'h0;
    localparam logic [3:0] OFS_CONTROL_TWO = 4'h1;
    localparam logic [3:0] OFS_FLAG_ZERO = 4'h2;
    // reset values
    localparam logic [15:0] RST_CONTROL_ONE = 16'h0000;
    localparam logic [15:0] RST_CONTROL_TWO = 16'h0000;
    localparam logic [15:0] RST_FLAG_ZERO = 16'h0000;
    // implemented bits (everything else ignores writes and reads zero, bar control two bit 14, which reads the timed block)
    localparam logic [15:0] MASK_CONTROL_ONE = 16'hFFDE;
    localparam logic [15:0] MASK_CONTROL_TWO_RW = 16'h8007;
    localparam logic [15:0] MASK_FLAG_ZERO = 16'h7FEF;
    // control register one field positions
    localparam int unsigned B_NESTING_DISABLE = 15;
    localparam int unsigned B_ACC_A_OVERFLOW = 14;
    localparam int unsigned B_ACC_B_OVERFLOW = 13;
    localparam int unsigned B_ACC_A_CATASTROPHIC = 12;
    localparam int unsigned B_ACC_B_CATASTROPHIC = 11;
    localparam int unsigned B_ACC_A_OVF_TRAP_EN = 10;
    localparam int unsigned B_ACC_B_OVF_TRAP_EN = 9;
    localparam int unsigned B_CATASTROPHIC_TRAP_EN = 8;
    localparam int unsigned B_BAD_SHIFT = 7;
    localparam int unsigned B_DIVIDE_BY_ZERO = 6;
    localparam int unsigned B_ARITH_TRAP = 4;
    localparam int unsigned B_ADDRESS_TRAP = 3;
    localparam int unsigned B_STACK_TRAP = 2;
    localparam int unsigned B_CLOCK_FAILURE_TRAP = 1;
    // control register two field positions
    localparam int unsigned B_ALTERNATE_VECTOR = 15;
    localparam int unsigned B_TIMED_BLOCK = 14;
    localparam int unsigned B_EXT_POLARITY_LSB = 0;
    // flag register zero: external request zero flag
    localparam int unsigned B_EXT_REQ0_FLAG = 0;
    // priority of timed disable: requests below this are held off
    localparam logic [3:0] LEVEL_TIMED_BLOCK = 4'h7;

    // arithmetic and hard trap causes from the core, one-cycle pulses
    typedef struct packed {
        logic acc_a_overflow;
        logic acc_b_overflow;
        logic acc_a_catastrophic;
        logic acc_b_catastrophic;
        logic bad_shift;
        logic divide_by_zero;
        logic address_error;
        logic stack_error;
        logic clock_failure;
    } icsr_trap_s;

    // context covered by the one-level shadow
    typedef struct packed {
        logic digit_carry;
        logic negative;
        logic overflow;
        logic zero;
        logic carry;
        logic [3:0][15:0] work_reg;
    } icsr_context_s;
endpackage : icsr_pkg

// >>> verilog/icsr_ctrl.sv
/*
 * icsr_ctrl: interrupt control and status registers, external edge
 * requests, one-level fast context shadow, request evaluation, wake-up.
 * Assumes the core gives one-cycle strobes synchronous to clk, and that
 * enable and priority settings of each flag come from elsewhere.
 */
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ns

// How it works
// R01 - one shadow level: status flags, work regs 0-3
// R02 - shadow reached only by push/pop instructions
// R03 - push copies context, pop restores it
// R04 - software: no nested push/pop across priorities
// R05 - three edge-sensitive external request inputs
// R06 - control two bits 2..0: one means falling
// R07 - sleep/idle: request and wake together
// R08 - control one bit 15 disables nesting
// R09 - bits 14,13: accumulator overflow trap causes
// R10 - bits 12,11: catastrophic overflow trap causes
// R11 - bits 10,9,8: overflow trap enables
// R12 - bits 7,6: bad shift, divide by zero
// R13 - bit 4: arithmetic overflow trap occurred
// R14 - bits 3,2,1: address, stack, clock traps
// R15 - control two bit 15: alternate vector table
// R16 - control two bit 14: timed disable active, read-only
// R17 - unimplemented bits read zero, ignore writes
// R18 - flag register zero source bit map
// R19 - implemented bits read/write, reset to zero
// R20 - sample flags each instruction cycle, compare priority
// R21 - two-stage sync, edge sets flag always
module icsr_ctrl (
    input wire logic clk, // 25 MHz system clock
    input wire logic rst_n, // asynchronous, active low
    // register port
    input wire logic [icsr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [icsr_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [icsr_pkg::DATA_W-1:0] reg_rdata,
    // fast context shadow
    input wire logic shadow_push,
    input wire logic shadow_pop,
    input wire icsr_pkg::icsr_context_s cur_context,
    output icsr_pkg::icsr_context_s restore_context,
    output logic restore_valid,
    // external request pins
    input wire logic [icsr_pkg::EXT_N-1:0] external_request_inputs,
    output logic [icsr_pkg::EXT_N-1:0] ext_req_edge,
    // peripheral events feeding flag register zero
    input wire logic [icsr_pkg::DATA_W-1:0] periph_event,
    // trap causes from the core
    input wire icsr_pkg::icsr_trap_s trap_event,
    output logic arith_trap_pending,
    output logic hard_trap_pending,
    // enable and priority of each flag in flag register zero
    input wire logic [icsr_pkg::DATA_W-1:0] interrupt_enable_regs,
    input wire logic [icsr_pkg::DATA_W-1:0][icsr_pkg::PRIO_W-1:0] flag_priority,
    input wire logic [icsr_pkg::LEVEL_W-1:0] cpu_priority_level,
    input wire logic instr_cycle_start,
    input wire logic isr_active,
    input wire logic timed_irq_block_active,
    // power state and request out
    input wire logic sleep_active,
    input wire logic idle_active,
    output logic irq_request,
    output logic [icsr_pkg::PRIO_W-1:0] irq_priority,
    output logic wake_up,
    output logic nesting_disable,
    output logic alternate_vector_select
);

    // highest priority among a set of pending flags
    function automatic logic [icsr_pkg::PRIO_W-1:0] max_prio(
        input logic [icsr_pkg::DATA_W-1:0] pend,
        input logic [icsr_pkg::DATA_W-1:0][icsr_pkg::PRIO_W-1:0] prio
    );
        logic [icsr_pkg::PRIO_W-1:0] best;
        best = '0;
        for (int i = 0; i < icsr_pkg::DATA_W; i++) begin
            if (pend[i] && (prio[i] > best)) begin
                best = prio[i];
            end
        end
        return best;
    endfunction : max_prio

    // register state
    logic [15:0] control_one_ff; // trap flags, enables, nesting
    logic [15:0] control_two_rw_ff; // writable part of control two
    logic [15:0] flag_zero_ff; // peripheral request flags
    logic [15:0] nxt_control_one;
    logic [15:0] nxt_control_two_rw;
    logic [15:0] nxt_flag_zero;
    logic [15:0] rdata_ff; // read data, valid one cycle after strobe
    logic [15:0] nxt_rdata;

    // shadow state
    icsr_pkg::icsr_context_s shadow_ff; // the one shadow level
    icsr_pkg::icsr_context_s restore_ff; // context handed back on pop
    logic restore_valid_ff;

    // synchroniser and edge detection state
    logic [2:0] ext_meta_ff; // first stage, read only by second stage
    logic [2:0] ext_sync_ff; // second stage
    logic [2:0] ext_prev_ff; // previous synchronised level
    logic [2:0] ext_edge_ff; // registered edge pulses

    // request evaluation state
    logic [15:0] sampled_ff; // flags seen at instruction cycle start
    logic irq_ff;
    logic [2:0] irq_prio_ff;
    logic wake_ff;

    // address decode
    wire sel_one = (reg_addr == icsr_pkg::OFS_CONTROL_ONE);
    wire sel_two = (reg_addr == icsr_pkg::OFS_CONTROL_TWO);
    wire sel_flag = (reg_addr == icsr_pkg::OFS_FLAG_ZERO);
    wire wr_one = reg_wr && sel_one;
    wire wr_two = reg_wr && sel_two;
    wire wr_flag = reg_wr && sel_flag;

    // polarity bits of control two
    wire [2:0] ext_polarity = control_two_rw_ff[icsr_pkg::B_EXT_POLARITY_LSB +: 3];

    // edge of the chosen direction; the level alone never fires
    wire [2:0] rise = ext_sync_ff & ~ext_prev_ff; // [R05]
    wire [2:0] fall = ~ext_sync_ff & ext_prev_ff; // [R05]
    wire [2:0] ext_edge = (ext_polarity & fall) | (~ext_polarity & rise); // [R06]

    // trap causes qualified by their enables
    wire en_a_ovf = control_one_ff[icsr_pkg::B_ACC_A_OVF_TRAP_EN]; // [R11]
    wire en_b_ovf = control_one_ff[icsr_pkg::B_ACC_B_OVF_TRAP_EN]; // [R11]
    wire en_cat = control_one_ff[icsr_pkg::B_CATASTROPHIC_TRAP_EN]; // [R11]
    wire take_a_ovf = trap_event.acc_a_overflow && en_a_ovf; // [R09]
    wire take_b_ovf = trap_event.acc_b_overflow && en_b_ovf; // [R09]
    wire take_a_cat = trap_event.acc_a_catastrophic && en_cat; // [R10]
    wire take_b_cat = trap_event.acc_b_catastrophic && en_cat; // [R10]
    // shift and divide faults trap unconditionally
    wire take_arith = take_a_ovf || take_b_ovf || take_a_cat || take_b_cat
                      || trap_event.bad_shift || trap_event.divide_by_zero; // [R13]

    // hardware set terms of control one, one bit per cause
    logic [15:0] set_one;
    always_comb begin
        set_one = '0;
        set_one[icsr_pkg::B_ACC_A_OVERFLOW] = take_a_ovf; // [R09]
        set_one[icsr_pkg::B_ACC_B_OVERFLOW] = take_b_ovf; // [R09]
        set_one[icsr_pkg::B_ACC_A_CATASTROPHIC] = take_a_cat; // [R10]
        set_one[icsr_pkg::B_ACC_B_CATASTROPHIC] = take_b_cat; // [R10]
        set_one[icsr_pkg::B_BAD_SHIFT] = trap_event.bad_shift; // [R12]
        set_one[icsr_pkg::B_DIVIDE_BY_ZERO] = trap_event.divide_by_zero; // [R12]
        set_one[icsr_pkg::B_ARITH_TRAP] = take_arith; // [R13]
        set_one[icsr_pkg::B_ADDRESS_TRAP] = trap_event.address_error; // [R14]
        set_one[icsr_pkg::B_STACK_TRAP] = trap_event.stack_error; // [R14]
        set_one[icsr_pkg::B_CLOCK_FAILURE_TRAP] = trap_event.clock_failure; // [R14]
    end

    // flag register zero set terms; bit 0 comes from external request 0
    wire [15:0] set_flag = (periph_event
                            | {15'h0000, ext_edge[icsr_pkg::B_EXT_REQ0_FLAG]})
                           & icsr_pkg::MASK_FLAG_ZERO; // [R18] [R21]

    // next values: write takes the bus data, a hardware set wins over it
    assign nxt_control_one = ((wr_one ? reg_wdata : control_one_ff) | set_one)
                             & icsr_pkg::MASK_CONTROL_ONE; // [R17] [R19]
    assign nxt_control_two_rw = (wr_two ? reg_wdata : control_two_rw_ff)
                                & icsr_pkg::MASK_CONTROL_TWO_RW; // [R17] [R19]
    assign nxt_flag_zero = ((wr_flag ? reg_wdata : flag_zero_ff) | set_flag)
                           & icsr_pkg::MASK_FLAG_ZERO; // [R17] [R18] [R19]

    // read view of control two: the timed-block bit follows the core live
    wire [15:0] control_two_view = control_two_rw_ff
        | ({15'h0000, timed_irq_block_active} << icsr_pkg::B_TIMED_BLOCK); // [R16]

    // read mux; shadow is never on it, unmapped reads give zero
    assign nxt_rdata = !reg_rd ? 16'h0000 :
                       sel_one ? control_one_ff :
                       sel_two ? control_two_view :
                       sel_flag ? flag_zero_ff :
                       16'h0000; // [R02] [R17]

    // register file; writes to the timed-block bit are dropped by the mask
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_one_ff <= icsr_pkg::RST_CONTROL_ONE; // [R19]
            control_two_rw_ff <= icsr_pkg::RST_CONTROL_TWO; // [R19]
            flag_zero_ff <= icsr_pkg::RST_FLAG_ZERO; // [R19]
            rdata_ff <= 16'h0000;
        end else begin
            control_one_ff <= nxt_control_one;
            control_two_rw_ff <= nxt_control_two_rw;
            flag_zero_ff <= nxt_flag_zero;
            rdata_ff <= nxt_rdata;
        end
    end

    // two-stage synchroniser then one stage of history for edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta_ff <= 3'h0;
            ext_sync_ff <= 3'h0;
            ext_prev_ff <= 3'h0;
            ext_edge_ff <= 3'h0;
        end else begin
            ext_meta_ff <= external_request_inputs; // [R21]
            ext_sync_ff <= ext_meta_ff; // [R21]
            ext_prev_ff <= ext_sync_ff;
            ext_edge_ff <= ext_edge; // [R05]
        end
    end

    // shadow: one level only, a second push overwrites the first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_ff <= '0;
            restore_ff <= '0;
            restore_valid_ff <= 1'b0;
        end else begin
            if (shadow_push) begin
                shadow_ff <= cur_context; // [R01] [R03]
            end
            if (shadow_pop) begin
                restore_ff <= shadow_ff; // [R03]
            end
            restore_valid_ff <= shadow_pop; // [R02]
        end
    end

    // pending requests: sampled flag with its enable
    wire [15:0] pending = sampled_ff & interrupt_enable_regs; // [R20]
    wire [2:0] best_prio = max_prio(pending, flag_priority); // [R20]
    // nesting disabled: a running service routine is not preempted
    wire nest_block = control_one_ff[icsr_pkg::B_NESTING_DISABLE] && isr_active; // [R08]
    // timed disable holds off levels strictly below the blocking level
    wire timed_block = timed_irq_block_active
                       && ({1'b0, best_prio} < icsr_pkg::LEVEL_TIMED_BLOCK);
    wire prio_wins = ({1'b0, best_prio} > cpu_priority_level); // [R20]
    wire nxt_irq = prio_wins && !nest_block && !timed_block;
    wire low_power = sleep_active || idle_active;

    // request evaluation: flags are frozen at each instruction start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sampled_ff <= 16'h0000;
            irq_ff <= 1'b0;
            irq_prio_ff <= 3'h0;
            wake_ff <= 1'b0;
        end else begin
            if (instr_cycle_start) begin
                sampled_ff <= flag_zero_ff; // [R20]
            end
            irq_ff <= nxt_irq; // [R20]
            irq_prio_ff <= nxt_irq ? best_prio : 3'h0;
            // wake in the same cycle the request is raised
            wake_ff <= nxt_irq && low_power; // [R07]
        end
    end

    // outputs
    assign reg_rdata = rdata_ff;
    assign restore_context = restore_ff;
    assign restore_valid = restore_valid_ff;
    assign ext_req_edge = ext_edge_ff;
    assign irq_request = irq_ff; // [R07]
    assign irq_priority = irq_prio_ff;
    assign wake_up = wake_ff; // [R07]
    assign nesting_disable = control_one_ff[icsr_pkg::B_NESTING_DISABLE]; // [R08]
    assign alternate_vector_select = control_two_rw_ff[icsr_pkg::B_ALTERNATE_VECTOR]; // [R15]
    assign arith_trap_pending = control_one_ff[icsr_pkg::B_ARITH_TRAP]; // [R13]
    assign hard_trap_pending = control_one_ff[icsr_pkg::B_ADDRESS_TRAP]
                               | control_one_ff[icsr_pkg::B_STACK_TRAP]
                               | control_one_ff[icsr_pkg::B_CLOCK_FAILURE_TRAP]; // [R14]

endmodule : icsr_ctrl

// >>> verif/icsr_ctrl_properties.sv
/* icsr_ctrl_properties: port-level checks of icsr_ctrl, bound below.
 * Assumes one clock domain and an asynchronous active-low reset. */
`timescale 1ns/1ns
module icsr_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [icsr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [icsr_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [icsr_pkg::DATA_W-1:0] reg_rdata,
    input wire logic shadow_pop,
    input wire logic restore_valid,
    input wire logic [icsr_pkg::EXT_N-1:0] external_request_inputs,
    input wire logic [icsr_pkg::EXT_N-1:0] ext_req_edge,
    input wire icsr_pkg::icsr_trap_s trap_event,
    input wire logic arith_trap_pending,
    input wire logic hard_trap_pending,
    input wire logic timed_irq_block_active,
    input wire logic nesting_disable,
    input wire logic alternate_vector_select
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // read data stands only in the cycle after a read strobe
    property p_idle_rdata; !reg_rd |=> reg_rdata == 16'h0000; endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("stray read data");
    // timed block status is live, never a stored write
    property p_timed; reg_rd && reg_addr == 4'h1 |=> reg_rdata[14] == $past(timed_irq_block_active); endproperty
    a_timed: assert property (p_timed) else $error("timed block bit wrong");
    property p_nest; reg_wr && reg_addr == 4'h0 |=> nesting_disable == $past(reg_wdata[15]); endproperty
    a_nest: assert property (p_nest) else $error("nesting bit not written");
    property p_altvec; reg_wr && reg_addr == 4'h1 |=> alternate_vector_select == $past(reg_wdata[15]);
    endproperty
    a_altvec: assert property (p_altvec) else $error("vector select not written");
    // shift and divide causes are never gated by an enable
    property p_arith; trap_event.bad_shift || trap_event.divide_by_zero |=> arith_trap_pending; endproperty
    a_arith: assert property (p_arith) else $error("arith trap flag missing");
    property p_hard;
        trap_event.address_error || trap_event.stack_error || trap_event.clock_failure |=> hard_trap_pending;
    endproperty
    a_hard: assert property (p_hard) else $error("hard trap flag missing");
    property p_restore; restore_valid == $past(shadow_pop); endproperty
    a_restore: assert property (p_restore) else $error("restore pulse misplaced");
    // a detected edge needs a pin change a few cycles earlier, never a level
    property p_ext; |ext_req_edge |-> $past(external_request_inputs, 3) != $past(external_request_inputs, 6);
    endproperty
    a_ext: assert property (p_ext) else $error("edge without pin change");
endmodule : icsr_chk
bind icsr_ctrl icsr_chk chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .shadow_pop, .restore_valid, .external_request_inputs, .ext_req_edge, .trap_event,
    .arith_trap_pending, .hard_trap_pending, .timed_irq_block_active, .nesting_disable,
    .alternate_vector_select);

// >>> verif/icsr_core_model.sv
/* icsr_core_model: core side of the shadow port, push/pop strobes and live
 * context. Assumes its tasks are called from the bench, one at a time. */
`timescale 1ns/1ns
module icsr_core_model (
    input wire logic clk,
    output logic shadow_push,
    output logic shadow_pop,
    output icsr_pkg::icsr_context_s cur_context,
    input wire icsr_pkg::icsr_context_s restore_context,
    input wire logic restore_valid
);
    initial begin
        shadow_push = 1'b0;
        shadow_pop = 1'b0;
        cur_context = '0;
    end
    // one frame per routine; no push inside a higher routine
    task automatic push(input icsr_pkg::icsr_context_s c);
        @(posedge clk);
        cur_context <= c;
        shadow_push <= 1'b1;
        @(posedge clk);
        shadow_push <= 1'b0;
        cur_context <= ~c; // live state moves on, so a late copy shows
    endtask : push
    task automatic pop(output icsr_pkg::icsr_context_s c, output logic v);
        @(posedge clk);
        shadow_pop <= 1'b1;
        @(posedge clk);
        shadow_pop <= 1'b0;
        @(negedge clk);
        c = restore_context;
        v = restore_valid;
    endtask : pop
endmodule : icsr_core_model

// >>> verif/tb.sv
/* tb: self-checking bench for icsr_ctrl with a core-side model.
 * Assumes the checker binds itself to the design from its own file. */
`timescale 1ns/1ns
module tb;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, v;
    logic [3:0] reg_addr = 4'h0, cpu_lvl = 4'h0, a;
    logic [15:0] reg_wdata = 16'h0000, periph_event = 16'h0000, irq_en = 16'h0008, d, reg_rdata;
    logic shadow_push, shadow_pop, restore_valid, arith_trap_pending, hard_trap_pending;
    logic instr_start = 1'b0, isr_active = 1'b0, tblk = 1'b0, sleep_active = 1'b0;
    logic irq_request, wake_up, idle_active = 1'b0;
    logic [2:0] pins = 3'h0, ext_req_edge, seen, irq_priority;
    icsr_pkg::icsr_context_s cur_context, restore_context, ctx_a, ctx_b;
    icsr_pkg::icsr_trap_s trap_event = '0;
    int fail_count = 0, samples_checked = 0, pos [9] = '{14, 13, 12, 11, 7, 6, 3, 2, 1};
    integer seed = 10865;
    // request cases: level[7:4], in routine, timed block, nesting off, hit
    logic [7:0] cases [8] = '{8'h31, 8'h60, 8'h41, 8'h3A, 8'h33, 8'h39, 8'h34, 8'h50};
    always #20 clk = ~clk;
    icsr_ctrl dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .shadow_push, .shadow_pop, .cur_context, .restore_context, .restore_valid,
        .external_request_inputs(pins), .ext_req_edge, .periph_event, .trap_event,
        .arith_trap_pending, .hard_trap_pending, .interrupt_enable_regs(irq_en),
        .flag_priority({16{3'h5}}), .cpu_priority_level(cpu_lvl),
        .instr_cycle_start(instr_start), .isr_active, .timed_irq_block_active(tblk),
        .sleep_active, .idle_active, .irq_request, .irq_priority, .wake_up,
        .nesting_disable(), .alternate_vector_select());
    icsr_core_model core (.clk, .shadow_push, .shadow_pop, .cur_context, .restore_context,
        .restore_valid);
    task automatic chk(input string what, input logic [68:0] e, input logic [68:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %0h got %0h", what, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] ad, input logic [15:0] dt);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= dt;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] ad, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("reg_rdata", 69'(e), 69'(reg_rdata));
    endtask : rd
    // collect edge pulses over long enough for the synchronizer
    task automatic watch(output logic [2:0] s);
        s = 3'h0;
        repeat (8) begin
            @(negedge clk);
            s = s | ext_req_edge;
        end
    endtask : watch
    function automatic logic [15:0] keep(input logic [3:0] ad, input logic [15:0] dt);
        case (ad)
            icsr_pkg::OFS_CONTROL_ONE: return dt & icsr_pkg::MASK_CONTROL_ONE;
            icsr_pkg::OFS_CONTROL_TWO: return dt & icsr_pkg::MASK_CONTROL_TWO_RW;
            icsr_pkg::OFS_FLAG_ZERO: return dt & icsr_pkg::MASK_FLAG_ZERO;
            default: return 16'h0000;
        endcase
    endfunction : keep
    // overflow causes need their enable; shift and divide always land
    function automatic logic [15:0] trap_bits(input int i, input bit en);
        if (i < 4 && !en) return 16'h0000;
        return (16'h0001 << pos[i]) | (i < 6 ? 16'h0010 : 16'h0000);
    endfunction : trap_bits
    task automatic print_verdict();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // flags before control two; a polarity write alone never raises a flag, only a pin edge does
        for (int i = 0; i < 4; i++) begin
            a = 4'(3 - i);
            rd(a, 16'h0000);
            wr(a, 16'hFFFF);
            rd(a, keep(a, 16'hFFFF));
            wr(a, 16'h0000);
        end
        for (int i = 0; i < 40; i++) begin
            d = 16'($random(seed));
            a = {2'b00, d[0], 1'b0};
            wr(a, d);
            rd(a, keep(a, d));
        end
        @(posedge clk);
        tblk <= 1'b1;
        wr(4'h1, 16'h0000);
        rd(4'h1, 16'h4000);
        @(posedge clk);
        tblk <= 1'b0;
        periph_event <= 16'hFFFF;
        @(posedge clk);
        periph_event <= 16'h0000;
        rd(4'h2, icsr_pkg::MASK_FLAG_ZERO);
        for (int i = 0; i < 18; i++) begin
            wr(4'h0, i[0] ? 16'h0700 : 16'h0000);
            @(posedge clk);
            trap_event <= 9'(9'h100 >> (i / 2));
            @(posedge clk);
            trap_event <= '0;
            rd(4'h0, (i[0] ? 16'h0700 : 16'h0000) | trap_bits(i / 2, i[0]));
        end
        for (int p = 0; p < 2; p++) begin
            wr(4'h1, p[0] ? 16'h0007 : 16'h0000);
            pins <= {3{p[0]}};
            repeat (8) @(posedge clk);
            for (int c = 0; c < 3; c++) begin
                wr(4'h2, 16'h0000);
                pins[c] <= ~p[0];
                watch(seen);
                chk("ext_req_edge", 69'(3'h1 << c), 69'(seen));
                rd(4'h2, c == 0 ? 16'h0001 : 16'h0000);
                @(posedge clk);
                pins[c] <= p[0];
                watch(seen);
                chk("ext_req_edge", 69'(0), 69'(seen));
            end
        end
        wr(4'h1, 16'h0000);
        for (int k = 0; k < 8; k++) begin
            wr(4'h0, {cases[k][1], 15'h0000});
            wr(4'h2, 16'h0008);
            {cpu_lvl, isr_active, tblk} <= cases[k][7:2];
            sleep_active <= k[0];
            idle_active <= k[1] & ~k[0];
            @(posedge clk);
            instr_start <= 1'b1;
            @(posedge clk);
            instr_start <= 1'b0;
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("irq_request", 69'(cases[k][0]), 69'(irq_request));
            chk("irq_priority", cases[k][0] ? 69'(5) : 69'(0), 69'(irq_priority));
            chk("wake_up", 69'(cases[k][0] & (k[0] | k[1])), 69'(wake_up));
        end
        ctx_a = 69'({$random(seed), $random(seed), $random(seed)});
        ctx_b = ~ctx_a;
        core.push(ctx_a);
        core.push(ctx_b);
        core.pop(ctx_a, v);
        chk("restore_context", ctx_b, ctx_a);
        chk("restore_valid", 69'(1), 69'(v));
        print_verdict();
    end
    // about ninety-five times the cycles the sequence above needs
    initial begin
        #2000000;
        fail_count++;
        print_verdict();
    end
endmodule : tb
